// [common/spi_port_defines.svh]
// Register map, field positions, reset values and divider counts for the SPI status/data port.
// Assumes an 8-bit I/O register bus; data-space addresses sit a fixed distance above I/O offsets.
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTRL_OFS 8'h0d
`define STAT_OFS 8'h0e
`define DATA_OFS 8'h0f
`define DS_DISTANCE 8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_RESET 8'h00
`define CB_IRQ_EN 7
`define CB_ENABLE 6
`define CB_ORDER 5
`define CB_MASTER 4
`define CB_CPOL 3
`define CB_CPHA 2
`define CB_RATE_HI 1
`define CB_RATE_LO 0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SB_DONE 7
`define SB_WRITE_COLLISION_FLAG 6
`define SB_DOUBLE 0
`define DATA_RESET 8'h00

// ----------------------------------------------------------------
// Half SCK period in system clocks (divisor / 2), halved again at double rate
// ----------------------------------------------------------------
`define HALF_DIV4 7'd2
`define HALF_DIV16 7'd8
`define HALF_DIV64 7'd32
`define HALF_DIV128 7'd64
`define HALF_ONE 7'd1
`define EDGES_LAST 4'hf
`define BITS_LAST 3'h7

`endif

// [common/spi_port_pkg.sv]
// Types shared by the SPI status/data port.
// Assumes the constants header is included where numbers are needed.
package spi_port_pkg;

  typedef enum logic [0:0] {
    MST_IDLE  = 1'b0,
    MST_SHIFT = 1'b1
  } mst_state_t;

endpackage

// [src/spi_port.sv]
// SPI status/data port: control, status and data registers, master SCK generator, slave link.
// Assumes a single-cycle I/O strobe bus on clk and a pad block that resolves the enables.
//
// Overview of operation
// - A finished byte transfer sets the transfer-done flag at bit 7 of the status register.
// - An interrupt request is raised while the done flag, its enable and global enable are set.
// - In master mode a low slave-select input configured as input also sets the done flag.
// - Executing this unit's interrupt vector clears the done flag.
// - Reading status with the done flag set, then accessing data, clears the done flag.
// - Writing the data register during a transfer sets the collision flag at bit 6.
// - Reading status with the collision flag set, then accessing data, clears both flags.
// - The double-rate bit at status bit 0 doubles the master SCK frequency.
// - At double rate the shortest SCK period is two system clock periods.
// - In master mode a data write while idle loads the shifter and starts a byte, bit 7 being the most significant.
// - A data read returns the receive buffer, not the value last written.
// - The data register answers at I/O offset 0x0F and data-space address 0x2F.
// - Master SCK divides the system clock by 4, 16, 64, 128, or 2, 8, 32, 64 when doubled.
// - A low slave-select configured as input in master mode clears the master bit and falls back to slave.
`timescale 1ns/1ns
`include "spi_port_defines.svh"
`default_nettype none

module spi_port
  import spi_port_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic nrst,
  // I/O register bus
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // Processor interface
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic irq,
  // Slave-select pin
  input wire logic ss_n_pin,
  input wire logic ss_is_input,
  // Link clock from the external master
  input wire logic sck_link,
  // SCK pin
  output logic sck_out,
  output logic sck_oe,
  // Data pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs) || (a == (ofs + `DS_DISTANCE));
  endfunction

  function automatic logic [7:0] order(input logic [7:0] d, input logic lsb_first);
    logic [7:0] r;
    r = d;
    if (lsb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    order = r;
  endfunction

  function automatic logic [6:0] half_period(input logic [1:0] rs, input logic dbl);
    logic [6:0] h;
    h = `HALF_DIV4;
    case (rs)
      2'h0: h = `HALF_DIV4;
      2'h1: h = `HALF_DIV16;
      2'h2: h = `HALF_DIV64;
      default: h = `HALF_DIV128;
    endcase
    if (dbl) begin
      h = h >> 1;
    end
    half_period = h;
  endfunction

  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic done_q, write_collision_flag_q, dbl_q;
  logic arm_done_q, arm_write_collision_flag_q;
  logic [7:0] tx_hold_q, rx_buf_q, rdata_q;
  logic irq_q;
  logic ss_m_q, ss_s_q, miso_m_q, miso_s_q;
  logic slv_tgl_m_q, slv_tgl_s_q, slv_tgl_d_q;
  logic slv_en_q;
  mst_state_t state_q;
  logic [6:0] div_q;
  logic [3:0] edge_q;
  logic [7:0] shreg_q;
  logic sck_q, mosi_q, sck_oe_q, mosi_oe_q, miso_oe_q;

  // Link-domain state
  logic [2:0] rx_cnt_q, tx_cnt_q;
  logic [7:0] rx_shift_q, rx_byte_q, tx_shift_q;
  logic slv_tgl_q, miso_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire ctrl_sel = hit(io_addr, `CTRL_OFS);
  wire stat_sel = hit(io_addr, `STAT_OFS);
  wire data_sel = hit(io_addr, `DATA_OFS);
  wire ctrl_wr = io_wr && ctrl_sel;
  wire stat_wr = io_wr && stat_sel;
  wire stat_rd = io_rd && stat_sel;
  wire data_wr = io_wr && data_sel;
  wire data_acc = (io_wr || io_rd) && data_sel;

  wire enable = ctrl_q[`CB_ENABLE];
  wire master = ctrl_q[`CB_MASTER];
  wire cpol = ctrl_q[`CB_CPOL];
  wire cpha = ctrl_q[`CB_CPHA];
  wire lsb_first = ctrl_q[`CB_ORDER];
  wire [1:0] rate = {ctrl_q[`CB_RATE_HI], ctrl_q[`CB_RATE_LO]};
  wire [6:0] half = half_period(rate, dbl_q);

  wire mst_busy = (state_q == MST_SHIFT);
  wire slv_busy = slv_en_q && !ss_s_q;
  wire in_prog = mst_busy || slv_busy;
  wire ss_fault = enable && master && ss_is_input && !ss_s_q;
  wire start = data_wr && !in_prog && enable && master && !ss_fault;
  wire tick = mst_busy && (div_q == (half - `HALF_ONE));
  wire leading = !edge_q[0];
  wire sample_edge = tick && (leading != cpha);
  wire setup_edge = tick && (leading == cpha);
  wire mst_last = tick && (edge_q == `EDGES_LAST);
  wire [7:0] shreg_shift = {shreg_q[6:0], miso_s_q};
  wire [7:0] shreg_d = sample_edge ? shreg_shift : shreg_q;
  wire [7:0] wr_ordered = order(io_wdata, lsb_first);
  wire [7:0] tx_ordered = order(tx_hold_q, lsb_first);
  wire slv_done = slv_tgl_s_q != slv_tgl_d_q;

  wire done_set = mst_last || slv_done || ss_fault;
  wire done_clr = irq_vector_ack || (data_acc && (arm_done_q || arm_write_collision_flag_q));
  wire done_d = done_set ? 1'b1 : (done_clr ? 1'b0 : done_q);
  wire write_collision_flag_set = data_wr && in_prog;
  wire write_collision_flag_clr = data_acc && arm_write_collision_flag_q;
  wire write_collision_flag_d = write_collision_flag_set ? 1'b1 : (write_collision_flag_clr ? 1'b0 : write_collision_flag_q);

  wire [7:0] stat_val = {done_q, write_collision_flag_q, 5'h00, dbl_q};
  wire [7:0] rdata_d = ctrl_sel ? ctrl_q : (stat_sel ? stat_val : (data_sel ? rx_buf_q : 8'h00));
  wire [7:0] ctrl_d = ss_fault ? (ctrl_q & ~(8'h01 << `CB_MASTER)) : ctrl_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_m_q <= 1'b1;
      ss_s_q <= 1'b1;
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
      slv_tgl_m_q <= 1'b0;
      slv_tgl_s_q <= 1'b0;
      slv_tgl_d_q <= 1'b0;
    end else begin
      ss_m_q <= ss_n_pin;
      ss_s_q <= ss_m_q;
      miso_m_q <= miso_in;
      miso_s_q <= miso_m_q;
      slv_tgl_m_q <= slv_tgl_q;
      slv_tgl_s_q <= slv_tgl_m_q;
      slv_tgl_d_q <= slv_tgl_s_q;
    end
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `CTRL_RESET;
      dbl_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= io_wdata;
      end else begin
        ctrl_q <= ctrl_d;
      end
      if (stat_wr) begin
        dbl_q <= io_wdata[`SB_DOUBLE];
      end
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      arm_done_q <= 1'b0;
      arm_write_collision_flag_q <= 1'b0;
    end else begin
      done_q <= done_d;
      write_collision_flag_q <= write_collision_flag_d;
      if (stat_rd) begin
        arm_done_q <= done_q;
        arm_write_collision_flag_q <= write_collision_flag_q;
      end else if (data_acc) begin
        arm_done_q <= 1'b0;
        arm_write_collision_flag_q <= 1'b0;
      end
    end
  end

  // Data, read path and interrupt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold_q <= `DATA_RESET;
      rx_buf_q <= `DATA_RESET;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      slv_en_q <= 1'b0;
    end else begin
      if (data_wr && !in_prog) begin
        tx_hold_q <= io_wdata;
      end
      if (mst_last) begin
        rx_buf_q <= order(shreg_d, lsb_first);
      end else if (slv_done) begin
        rx_buf_q <= order(rx_byte_q, lsb_first);
      end
      rdata_q <= rdata_d;
      irq_q <= done_q && ctrl_q[`CB_IRQ_EN] && global_irq_enable;
      slv_en_q <= enable && !master;
    end
  end

  // ----------------------------------------------------------------
  // Master shifter and SCK divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= MST_IDLE;
      div_q <= 7'h00;
      edge_q <= 4'h0;
      shreg_q <= `DATA_RESET;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
    end else if (start) begin
      state_q <= MST_SHIFT;
      div_q <= 7'h00;
      edge_q <= 4'h0;
      shreg_q <= wr_ordered;
      sck_q <= cpol;
      if (!cpha) begin
        mosi_q <= wr_ordered[7];
      end
    end else if (!mst_busy || ss_fault) begin
      state_q <= MST_IDLE;
      div_q <= 7'h00;
      sck_q <= cpol;
    end else begin
      div_q <= tick ? 7'h00 : div_q + 7'h01;
      shreg_q <= shreg_d;
      if (tick) begin
        sck_q <= !sck_q;
        edge_q <= edge_q + 4'h1;
      end
      if (setup_edge) begin
        mosi_q <= shreg_q[7];
      end
      if (mst_last) begin
        state_q <= MST_IDLE;
      end
    end
  end

  // Pin enables follow mode; slave drives its output only while selected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      sck_oe_q <= enable && ctrl_d[`CB_MASTER];
      mosi_oe_q <= enable && ctrl_d[`CB_MASTER];
      miso_oe_q <= slv_busy;
    end
  end

  // ----------------------------------------------------------------
  // Slave link on the external SCK (mode 3: shift out falling, sample rising)
  // ----------------------------------------------------------------
  // Held in reset while deselected so a partial byte is dropped;
  // the external master keeps SCK at or below a quarter of clk
  wire link_rst_n = nrst && slv_en_q && !ss_n_pin;

  always_ff @(posedge sck_link or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_cnt_q <= 3'h0;
      rx_shift_q <= 8'h00;
    end else begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
      rx_shift_q <= {rx_shift_q[6:0], mosi_in};
    end
  end

  // Completed byte and its toggle survive deselect for the crossing
  always_ff @(posedge sck_link or negedge nrst) begin
    if (!nrst) begin
      rx_byte_q <= 8'h00;
      slv_tgl_q <= 1'b0;
    end else if (rx_cnt_q == `BITS_LAST) begin
      rx_byte_q <= {rx_shift_q[6:0], mosi_in};
      slv_tgl_q <= !slv_tgl_q;
    end
  end

  // Holding register is stable for the whole byte because colliding writes are dropped
  always_ff @(negedge sck_link or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_cnt_q <= 3'h0;
      tx_shift_q <= 8'h00;
      miso_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h0) begin
        miso_q <= tx_ordered[7];
        tx_shift_q <= {tx_ordered[6:0], 1'b0};
      end else begin
        miso_q <= tx_shift_q[7];
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_rdata = rdata_q;
  assign irq = irq_q;
  assign sck_out = sck_q;
  assign sck_oe = sck_oe_q;
  assign mosi_out = mosi_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_out = miso_q;
  assign miso_oe = miso_oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_DONE_ON_LAST: assert property (mst_last |=> done_q
    && rx_buf_q == order($past(shreg_d), lsb_first))
    else $error("done flag or buffer missing after last edge");
  AST_IRQ_RAISE: assert property ((done_q && ctrl_q[`CB_IRQ_EN] && global_irq_enable) |=> irq)
    else $error("irq not raised");
  AST_SS_FAULT: assert property (ss_fault && !ctrl_wr |=> done_q
    && !ctrl_q[`CB_MASTER] && !mst_busy)
    else $error("slave-select fault not handled");
  AST_VECTOR_CLR: assert property ((irq_vector_ack && !done_set) |=> !done_q)
    else $error("vector did not clear done flag");
  AST_READ_CLR: assert property ((stat_rd && done_q) ##1 (!io_rd && !io_wr)
    ##1 (data_acc && !done_set) |=> !done_q)
    else $error("status then data access did not clear done flag");
  AST_WRITE_COLLISION_FLAG_SET: assert property ((data_wr && in_prog) |=> write_collision_flag_q)
    else $error("collision flag not set");
  AST_WRITE_COLLISION_FLAG_CLR: assert property ((stat_rd && write_collision_flag_q) ##1 (!io_rd && !io_wr)
    ##1 (data_acc && !done_set && !write_collision_flag_set) |=> !write_collision_flag_q && !done_q)
    else $error("collision clear failed");
  AST_DOUBLE_FAST: assert property ((mst_busy && dbl_q && rate == 2'h0 && $rose(sck_q)
    && !ss_fault && !mst_last) |=> $fell(sck_q))
    else $error("doubled fastest rate not two clocks per period");
  AST_BASE_FAST: assert property ((mst_busy && !dbl_q && rate == 2'h0 && $rose(sck_q)
    && !ss_fault) |=> !$fell(sck_q) ##1 $fell(sck_q) || !mst_busy)
    else $error("divide-by-four half period wrong");
  AST_COLLIDE_KEEP: assert property ((data_wr && mst_busy && !tick && !ss_fault)
    |=> $stable(shreg_q) && $stable(tx_hold_q))
    else $error("colliding write disturbed the byte in flight");
  AST_DATA_READ: assert property ((io_rd && data_sel) |=> io_rdata == $past(rx_buf_q))
    else $error("data read does not return receive buffer");
  AST_STATUS_ZERO: assert property ((io_rd && stat_sel) |=> io_rdata[5:1] == 5'h00)
    else $error("unused status bits not zero");

endmodule

`default_nettype wire

// [sim/spi_far_end.sv]
// External SPI party: a mode 0 slave facing the master SCK, a mode 3 master on the link.
// Assumes the bench loads bytes through the tasks; mosi_in is inverted after a link transfer, other idle lines hold their last value.
`timescale 1ns/1ns
`default_nettype none

module spi_far_end (
  // Pins the block drives
  input wire logic sck_out,
  input wire logic mosi_out,
  input wire logic miso_out,
  // Pins this party drives
  output logic miso_in,
  output logic mosi_in,
  output logic sck_link,
  output logic ss_n_pin
);
  logic [7:0] slv_tx_q;
  logic [7:0] slv_rx_q;

  initial begin
    miso_in = 1'b0;
    mosi_in = 1'b0;
    sck_link = 1'b1;
    ss_n_pin = 1'b1;
    slv_tx_q = 8'h00;
    slv_rx_q = 8'h00;
  end

  // ----------------------------------------------------------------
  // Slave side: sample on rising SCK, shift on falling SCK
  // ----------------------------------------------------------------
  always @(posedge sck_out) slv_rx_q <= {slv_rx_q[6:0], mosi_out};
  always @(negedge sck_out) begin
    slv_tx_q = {slv_tx_q[6:0], ~slv_tx_q[7]};
    miso_in = slv_tx_q[7];
  end

  task load_slave(input logic [7:0] b);
    slv_tx_q = b;
    miso_in = b[7];
  endtask

  task set_select(input logic lvl);
    ss_n_pin = lvl;
  endtask

  // ----------------------------------------------------------------
  // Master side: SCK idles high and runs only inside the frame
  // ----------------------------------------------------------------
  task master_xfer(input logic [7:0] tx, output logic [7:0] rx);
    integer i;
    ss_n_pin = 1'b0;
    #40;
    // SCK kept at or below a quarter of the system clock
    for (i = 7; i >= 0; i--) begin
      sck_link = 1'b0;
      mosi_in = tx[i];
      #23;
      sck_link = 1'b1;
      rx[i] = miso_out;
      #22;
    end
    #100;
    ss_n_pin = 1'b1;
    mosi_in = ~mosi_in;
  endtask
endmodule

`default_nettype wire

// [sim/spi_status_and_data_port_test.sv]
// Self-checking bench for the SPI status/data port.
// Assumes the far-end model on the pins and the register map of the defines header.
`timescale 1ns/1ns
`include "spi_port_defines.svh"
`default_nettype none

module spi_status_and_data_port_test
  import spi_port_pkg::*;
;
  logic clk, nrst, io_wr, io_rd, global_irq_enable, irq_vector_ack, irq;
  logic [7:0] io_addr, io_wdata, io_rdata;
  logic ss_n_pin, ss_is_input, sck_link, sck_out, sck_oe;
  logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
  int err_count, num_checks, cycles;

  // SCK divisor for rate k[1:0], halved when k[2] is set
  function automatic int div_of(input int k);
    case (k)
      0: div_of = 4;
      1: div_of = 16;
      2: div_of = 64;
      3: div_of = 128;
      4: div_of = 2;
      5: div_of = 8;
      6: div_of = 32;
      default: div_of = 64;
    endcase
  endfunction

  spi_port DUT (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .irq_vector_ack(irq_vector_ack), .irq(irq),
    .ss_n_pin(ss_n_pin), .ss_is_input(ss_is_input), .sck_link(sck_link),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe));

  spi_far_end far (.sck_out(sck_out), .mosi_out(mosi_out), .miso_out(miso_out),
    .miso_in(miso_in), .mosi_in(mosi_in), .sck_link(sck_link), .ss_n_pin(ss_n_pin));

  // ----------------------------------------------------------------
  // Clock, hang limit, reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end

  task summarize();
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task step();
    @(posedge clk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    step();
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    step();
    io_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    step();
    io_addr = a;
    io_rd = 1'b1;
    step();
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task wait_done();
    logic [7:0] s;
    int n;
    s = 8'h00;
    n = 0;
    while (s[`SB_DONE] !== 1'b1 && n < 1000) begin
      rd(`STAT_OFS, s);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task test_regs();
    logic [7:0] d;
    rd(`CTRL_OFS, d);
    chk(d, 8'h00);
    rd(`STAT_OFS, d);
    chk(d, 8'h00);
    wr(`STAT_OFS, 8'hff);
    rd(`STAT_OFS + `DS_DISTANCE, d);
    chk(d, 8'h01);
    rd(8'h10, d);
    chk(d, 8'h00);
    wr(`STAT_OFS, 8'h00);
  endtask

  task test_master();
    logic [7:0] d, tx, rxb;
    int k, n;
    for (k = 0; k < 8; k++) begin
      tx = 8'h96 ^ k[7:0];
      rxb = 8'h3c + k[7:0];
      wr(`CTRL_OFS, 8'h50 | {6'h00, k[1:0]});
      wr(`STAT_OFS, {7'h00, k[2]});
      far.load_slave(rxb);
      wr(k[0] ? `DATA_OFS + `DS_DISTANCE : `DATA_OFS, tx);
      n = 0;
      while (sck_out !== 1'b1 && n < 300) begin
        step();
        n++;
      end
      n = 0;
      while (sck_out === 1'b1 && n < 300) begin
        step();
        n++;
      end
      while (sck_out !== 1'b1 && n < 300) begin
        step();
        n++;
      end
      chk(8'(n), 8'(div_of(k)));
      chk({6'h00, sck_oe, mosi_oe}, 8'h03);
      wait_done();
      rd(`STAT_OFS, d);
      chk(d, {1'b1, 6'h00, k[2]});
      rd(`DATA_OFS, d);
      if (div_of(k) >= 8) chk(d, rxb);
      chk(far.slv_rx_q, tx);
      rd(`STAT_OFS, d);
      chk(d, {7'h00, k[2]});
    end
    wr(`STAT_OFS, 8'h00);
  endtask

  task test_collision();
    logic [7:0] d;
    wr(`CTRL_OFS, 8'h51);
    far.load_slave(8'hc3);
    wr(`DATA_OFS, 8'h5a);
    repeat (20) step();
    wr(`DATA_OFS, 8'hff);
    rd(`STAT_OFS, d);
    chk(d, 8'h40);
    wait_done();
    rd(`STAT_OFS, d);
    chk(d, 8'hc0);
    rd(`DATA_OFS, d);
    chk(d, 8'hc3);
    chk(far.slv_rx_q, 8'h5a);
    rd(`STAT_OFS, d);
    chk(d, 8'h00);
  endtask

  task test_irq();
    logic [7:0] d;
    wr(`CTRL_OFS, 8'hd1);
    far.load_slave(8'h0f);
    wr(`DATA_OFS, 8'h11);
    wait_done();
    step();
    step();
    chk({7'h00, irq}, 8'h00);
    global_irq_enable = 1'b1;
    step();
    step();
    chk({7'h00, irq}, 8'h01);
    irq_vector_ack = 1'b1;
    step();
    irq_vector_ack = 1'b0;
    step();
    step();
    chk({7'h00, irq}, 8'h00);
    rd(`STAT_OFS, d);
    chk(d, 8'h00);
    global_irq_enable = 1'b0;
  endtask

  task test_fault();
    logic [7:0] d;
    wr(`CTRL_OFS, 8'h50);
    ss_is_input = 1'b1;
    far.set_select(1'b0);
    repeat (6) step();
    rd(`CTRL_OFS, d);
    chk(d, 8'h40);
    chk({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h01);
    rd(`STAT_OFS, d);
    chk(d, 8'h80);
    rd(`DATA_OFS, d);
    far.set_select(1'b1);
    ss_is_input = 1'b0;
    repeat (6) step();
  endtask

  task test_slave();
    logic [7:0] d, rx;
    wr(`CTRL_OFS, 8'h40);
    wr(`DATA_OFS, 8'ha5);
    far.master_xfer(8'h3c, rx);
    chk(rx, 8'ha5);
    wait_done();
    rd(`DATA_OFS, d);
    chk(d, 8'h3c);
  endtask

  initial begin
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    global_irq_enable = 1'b0;
    irq_vector_ack = 1'b0;
    ss_is_input = 1'b0;
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    test_regs();
    test_master();
    test_collision();
    test_irq();
    test_fault();
    test_slave();
    summarize();
  end
endmodule

`default_nettype wire
